// ==== hw/ppf_framer.sv ====
// Ping-pong burst framer with superframe (M-channel) bit exchange.
// Assumes line pins are asynchronous and host data is on i_clk_sys.
`timescale 1ns/100ps
module ppf_framer (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // Host payload in (to line)
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire logic [7:0] i_tx_data,
    // Host payload out (from line)
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    // Superframe transmit register write
    input wire logic i_sf_tx_wr,
    input wire logic [3:0] i_sf_tx_t_bits,
    input wire logic i_sf_tx_svc,
    // Superframe receive register read strobe
    input wire logic i_sf_rx_rd,
    output ppf_pkg::ppf_sf_rx_s o_sf_rx,
    // Line pins
    output ppf_pkg::ppf_sym_s o_line_tx,
    output logic o_line_tx_en,
    input wire logic i_line_rx_pos,
    input wire logic i_line_rx_neg,
    output ppf_pkg::ppf_phase_e o_phase
);
    localparam int BW = 14;
    localparam logic [BW-1:0] BURST_LAST = BW'(ppf_pkg::BURST_CYCLES - 1);
    localparam logic [BW-1:0] RX_START = BW'(ppf_pkg::BURST_CYCLES / 2);
    localparam logic [BW-1:0] PH_LEN = BW'(ppf_pkg::PHASE_CYCLES);
    localparam logic [7:0] BIT_LAST = 8'(ppf_pkg::BIT_CYCLES - 1);
    localparam logic [7:0] BIT_MID = 8'(ppf_pkg::BIT_CYCLES / 2);
    localparam logic [5:0] FR_LAST = 6'(ppf_pkg::FRAME_BITS - 1);
    localparam logic [5:0] M_POS = 6'(ppf_pkg::M_BIT_POS);

    ////////////////////////////////////////////////////////////////////////
    // Burst timing
    logic [BW-1:0] burst_cnt, next_burst_cnt;
    logic [7:0] bit_cnt, next_bit_cnt;
    logic [5:0] bit_idx, next_bit_idx;
    logic in_tx, in_rx, bit_tick, bit_mid, ph_start;

    assign in_tx = burst_cnt < PH_LEN;
    assign in_rx = (burst_cnt >= RX_START) && (burst_cnt < RX_START + PH_LEN);
    assign ph_start = (burst_cnt == '0) || (burst_cnt == RX_START);
    assign bit_tick = (in_tx || in_rx) && (bit_cnt == BIT_LAST);
    assign bit_mid = in_rx && (bit_cnt == BIT_MID);
    assign o_phase = in_tx ? ppf_pkg::PH_TX : (in_rx ? ppf_pkg::PH_RX : ppf_pkg::PH_IDLE);

    always_comb begin
        next_burst_cnt = (burst_cnt == BURST_LAST) ? '0 : burst_cnt + 1'b1;
        next_bit_cnt = (ph_start || bit_cnt == BIT_LAST) ? '0 : bit_cnt + 1'b1;
        next_bit_idx = bit_idx;
        if (ph_start) begin
            next_bit_idx = '0;
        end else if (bit_tick && bit_idx != FR_LAST) begin
            next_bit_idx = bit_idx + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            burst_cnt <= '0;
            bit_cnt <= '0;
            bit_idx <= '0;
        end else begin
            burst_cnt <= next_burst_cnt;
            bit_cnt <= next_bit_cnt;
            bit_idx <= next_bit_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host transmit FIFO; back-pressure stalls the host
    logic fifo_valid, fifo_pop;
    logic [7:0] fifo_data;

    ppf_fifo #(
        .WIDTH(ppf_pkg::DATA_W),
        .DEPTH(ppf_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_in_valid(i_tx_valid),
        .o_in_ready(o_tx_ready),
        .i_in_data(i_tx_data),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmit path: frame build, superframe slot and AMI coder
    logic [7:0] tx_shift, next_tx_shift;
    logic [2:0] tx_bpos, next_tx_bpos;
    logic tx_have, next_tx_have;
    logic [1:0] tx_slot, next_tx_slot;
    logic [3:0] tx_field, next_tx_field;
    logic [3:0] tx_out, next_tx_out;
    logic [1:0] tx_left, next_tx_left;
    logic tx_field_full, next_tx_field_full;
    logic tx_svc, next_tx_svc;
    logic tx_req, next_tx_req;
    logic last_pol, next_last_pol;
    ppf_pkg::ppf_sym_s sym, next_sym;
    logic next_tx_en, tx_en;
    logic tx_bit;
    logic m_bit;

    // payload taken from FIFO, framing added here
    assign fifo_pop = in_tx && ph_start && fifo_valid && !tx_have;

    // one M bit per frame, rotated over four slots
    // sync slot is a forced one
    // T slots from shifter, S slot from service latch
    always_comb begin
        case (tx_slot)
            ppf_pkg::SLOT_SYNC: m_bit = 1'b1;
            ppf_pkg::SLOT_S: m_bit = tx_svc;
            ppf_pkg::SLOT_T1, ppf_pkg::SLOT_T2: m_bit = tx_out[3];
            default: m_bit = 1'b0;
        endcase
    end

    // 38-bit frame: framing bit, 8 payload bits, fill, M bit, one fill bit
    always_comb begin
        if (bit_idx == '0) begin
            tx_bit = 1'b1;
        end else if (bit_idx <= 6'd8) begin
            tx_bit = tx_have ? tx_shift[3'(8 - bit_idx)] : 1'b1;
        end else if (bit_idx == M_POS) begin
            tx_bit = m_bit;
        end else begin
            tx_bit = 1'b0;
        end
    end

    always_comb begin
        next_tx_shift = tx_shift;
        next_tx_bpos = tx_bpos;
        next_tx_have = tx_have;
        next_tx_slot = tx_slot;
        next_tx_field = tx_field;
        next_tx_out = tx_out;
        next_tx_left = tx_left;
        next_tx_field_full = tx_field_full;
        next_tx_svc = tx_svc;
        next_tx_req = tx_req;
        next_last_pol = last_pol;
        next_sym = sym;
        next_tx_en = in_tx;
        if (fifo_pop) begin
            next_tx_shift = fifo_data;
            next_tx_have = 1'b1;
        end
        if (i_sf_tx_wr) begin
            next_tx_field = i_sf_tx_t_bits;
            next_tx_field_full = 1'b1;
            next_tx_svc = i_sf_tx_svc;
        end
        if (in_tx && bit_cnt == '0) begin
            // sync mark repeats last polarity as a violation
            if (bit_idx == M_POS && tx_slot == ppf_pkg::SLOT_SYNC) begin
                next_sym = last_pol ? 2'b10 : 2'b01;
            end else if (tx_bit) begin
                next_sym = last_pol ? 2'b01 : 2'b10;
                next_last_pol = !last_pol;
            end else begin
                next_sym = 2'b00;
            end
        end
        if (!in_tx) begin
            next_sym = 2'b00;
        end
        if (bit_tick && in_tx && bit_idx == FR_LAST) begin
            next_tx_have = 1'b0;
            next_tx_slot = tx_slot + 1'b1;
            if (tx_slot == ppf_pkg::SLOT_T1 || tx_slot == ppf_pkg::SLOT_T2) begin
                next_tx_out = {tx_out[2:0], 1'b0};
                if (tx_left != '0) begin
                    next_tx_left = tx_left - 1'b1;
                end
            end
            // group moved into shifter raises request
            // Load after the sync slot so the group leads a superframe
            if (tx_slot == ppf_pkg::SLOT_SYNC && tx_left == '0 && tx_field_full) begin
                next_tx_out = tx_field;
                next_tx_left = 2'd3;
                // A write in the load cycle stays pending instead of being lost
                next_tx_field_full = i_sf_tx_wr;
                next_tx_req = 1'b1;
            end
        end
        // read clears request, unless set in same cycle
        if (i_sf_rx_rd && !(next_tx_req && !tx_req)) begin
            next_tx_req = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tx_shift <= '0;
            tx_bpos <= '0;
            tx_have <= 1'b0;
            tx_slot <= ppf_pkg::SLOT_SYNC;
            tx_field <= ppf_pkg::T_FIELD_RST;
            tx_out <= ppf_pkg::T_FIELD_RST;
            tx_left <= '0;
            tx_field_full <= 1'b0;
            tx_svc <= ppf_pkg::SVC_RST;
            tx_req <= 1'b0;
            last_pol <= 1'b0;
            sym <= '0;
            tx_en <= 1'b0;
        end else begin
            tx_shift <= next_tx_shift;
            tx_bpos <= next_tx_bpos;
            tx_have <= next_tx_have;
            tx_slot <= next_tx_slot;
            tx_field <= next_tx_field;
            tx_out <= next_tx_out;
            tx_left <= next_tx_left;
            tx_field_full <= next_tx_field_full;
            tx_svc <= next_tx_svc;
            tx_req <= next_tx_req;
            last_pol <= next_last_pol;
            sym <= next_sym;
            tx_en <= next_tx_en;
        end
    end

    assign o_line_tx = sym;
    assign o_line_tx_en = tx_en;

    ////////////////////////////////////////////////////////////////////////
    // Line input synchronisers; first stage feeds only the second
    logic [1:0] rx_s1, rx_s2;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rx_s1 <= '0;
            rx_s2 <= '0;
        end else begin
            rx_s1 <= {i_line_rx_pos, i_line_rx_neg};
            rx_s2 <= rx_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive path: AMI decode, violation detect, field collection
    logic rx_mark, rx_pol_now, rx_viol;
    logic rx_last_pol, next_rx_last_pol;
    logic [7:0] rx_shift, next_rx_shift;
    logic [7:0] rx_data, next_rx_data;
    logic rx_valid, next_rx_valid;
    logic [1:0] rx_slot, next_rx_slot;
    logic [3:0] rx_coll, next_rx_coll;
    logic [2:0] rx_cnt, next_rx_cnt;
    logic [3:0] rx_field, next_rx_field;
    logic rx_rdy, next_rx_rdy;
    logic rx_svc, next_rx_svc;
    logic rx_locked, next_rx_locked;

    assign rx_mark = rx_s2[1] ^ rx_s2[0];
    assign rx_pol_now = rx_s2[1];
    assign rx_viol = rx_mark && (rx_pol_now == rx_last_pol);

    always_comb begin
        next_rx_last_pol = rx_last_pol;
        next_rx_shift = rx_shift;
        next_rx_data = rx_data;
        next_rx_valid = 1'b0;
        next_rx_slot = rx_slot;
        next_rx_coll = rx_coll;
        next_rx_cnt = rx_cnt;
        next_rx_field = rx_field;
        next_rx_rdy = rx_rdy;
        next_rx_svc = rx_svc;
        next_rx_locked = rx_locked;
        if (bit_mid) begin
            if (rx_mark) begin
                next_rx_last_pol = rx_pol_now;
            end
            if (bit_idx >= 6'd1 && bit_idx <= 6'd8) begin
                next_rx_shift = {rx_shift[6:0], rx_mark};
                if (bit_idx == 6'd8) begin
                    next_rx_data = {rx_shift[6:0], rx_mark};
                    next_rx_valid = 1'b1;
                end
            end
            if (bit_idx == M_POS) begin
                if (rx_viol) begin
                    next_rx_slot = ppf_pkg::SLOT_T1;
                    next_rx_locked = 1'b1;
                end else begin
                    next_rx_slot = rx_slot + 1'b1;
                end
                if (rx_locked && rx_slot == ppf_pkg::SLOT_S) begin
                    next_rx_svc = rx_mark;
                end
                if (rx_locked && !rx_viol &&
                    (rx_slot == ppf_pkg::SLOT_T1 || rx_slot == ppf_pkg::SLOT_T2)) begin
                    // first arrival ends in bit 3
                    next_rx_coll = {rx_coll[2:0], rx_mark};
                    next_rx_cnt = rx_cnt + 1'b1;
                    // four T-bits make the group ready
                    if (rx_cnt == 3'd3) begin
                        next_rx_field = {rx_coll[2:0], rx_mark};
                        next_rx_cnt = '0;
                        next_rx_rdy = 1'b1;
                    end
                end
            end
        end
        // read clears ready; a same-cycle set wins
        if (i_sf_rx_rd && !(next_rx_rdy && !rx_rdy)) begin
            next_rx_rdy = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rx_last_pol <= 1'b0;
            rx_shift <= '0;
            rx_data <= '0;
            rx_valid <= 1'b0;
            rx_slot <= ppf_pkg::SLOT_SYNC;
            rx_coll <= ppf_pkg::T_FIELD_RST;
            rx_cnt <= '0;
            rx_field <= ppf_pkg::T_FIELD_RST;
            rx_rdy <= 1'b0;
            rx_svc <= ppf_pkg::SVC_RST;
            rx_locked <= 1'b0;
        end else begin
            rx_last_pol <= next_rx_last_pol;
            rx_shift <= next_rx_shift;
            rx_data <= next_rx_data;
            rx_valid <= next_rx_valid;
            rx_slot <= next_rx_slot;
            rx_coll <= next_rx_coll;
            rx_cnt <= next_rx_cnt;
            rx_field <= next_rx_field;
            rx_rdy <= next_rx_rdy;
            rx_svc <= next_rx_svc;
            rx_locked <= next_rx_locked;
        end
    end

    assign o_rx_valid = rx_valid;
    assign o_rx_data = rx_data;
    assign o_sf_rx = '{t_bits: rx_field, rx_ready: rx_rdy, tx_request: tx_req, svc: rx_svc};

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_rd_no_set;
        i_sf_rx_rd && !(next_rx_rdy && !rx_rdy) && !(next_tx_req && !tx_req);
    endsequence

    property p_period;
        @(posedge i_clk_sys) disable iff (i_srst)
        (burst_cnt == BURST_LAST) |=> (burst_cnt == '0);
    endproperty
    a_period: assert property (p_period) else $error("burst period wrong");

    property p_phase_excl;
        @(posedge i_clk_sys) disable iff (i_srst)
        !(in_tx && in_rx);
    endproperty
    a_phase_excl: assert property (p_phase_excl) else $error("phases overlap");

    property p_zero_level;
        @(posedge i_clk_sys) disable iff (i_srst)
        !in_tx |=> (o_line_tx == 2'b00);
    endproperty
    a_zero_level: assert property (p_zero_level) else $error("line driven outside phase");

    property p_rd_clear;
        @(posedge i_clk_sys) disable iff (i_srst)
        s_rd_no_set |=> (!o_sf_rx.rx_ready && !o_sf_rx.tx_request);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read did not clear flags");

    property p_req_set;
        @(posedge i_clk_sys) disable iff (i_srst)
        $rose(tx_req) |-> ($past(tx_field_full) && $past(tx_slot) == ppf_pkg::SLOT_SYNC);
    endproperty
    a_req_set: assert property (p_req_set) else $error("request without load");

    property p_rdy_field;
        @(posedge i_clk_sys) disable iff (i_srst)
        $rose(rx_rdy) |-> $changed(rx_cnt);
    endproperty
    a_rdy_field: assert property (p_rdy_field) else $error("ready without group");

    property p_svc_hold;
        @(posedge i_clk_sys) disable iff (i_srst)
        !i_sf_tx_wr |=> $stable(tx_svc);
    endproperty
    a_svc_hold: assert property (p_svc_hold) else $error("service bit changed");

    property p_frame_len;
        @(posedge i_clk_sys) disable iff (i_srst)
        (bit_idx == FR_LAST) |=> (bit_idx == FR_LAST || bit_idx == '0);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame overran");
endmodule : ppf_framer

// ==== include/ppf_pkg.sv ====
// Package for the ping-pong burst superframe framer.
// Assumes a single 50 MHz system clock and synchronous active-high reset.
package ppf_pkg;

    // System clock
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 20;

    // Burst timing, in nanoseconds as printed
    localparam int BURST_PERIOD_NS = 250_000;
    localparam int PHASE_NS = 99_000;
    localparam int BURST_CYCLES = BURST_PERIOD_NS / CLK_NS;
    localparam int PHASE_CYCLES = PHASE_NS / CLK_NS;

    // Frame layout
    localparam int FRAME_BITS = 38;
    localparam int BIT_CYCLES = PHASE_CYCLES / FRAME_BITS;
    localparam int M_BIT_POS = 36;
    localparam int SF_LEN = 4;
    localparam int GROUP_LEN = 4;

    // Superframe slot positions
    localparam logic [1:0] SLOT_SYNC = 2'h0;
    localparam logic [1:0] SLOT_T1 = 2'h1;
    localparam logic [1:0] SLOT_S = 2'h2;
    localparam logic [1:0] SLOT_T2 = 2'h3;

    // Reset values
    localparam logic [3:0] T_FIELD_RST = 4'h0;
    localparam logic SVC_RST = 1'h0;

    // FIFO geometry
    localparam int FIFO_DEPTH = 4;
    localparam int DATA_W = 8;

    // Pseudo-ternary line symbol
    typedef struct packed {
        logic pos;
        logic neg;
    } ppf_sym_s;

    // Software view of the superframe exchange
    typedef struct packed {
        logic [3:0] t_bits;
        logic rx_ready;
        logic tx_request;
        logic svc;
    } ppf_sf_rx_s;

    typedef enum logic [1:0] {
        PH_TX = 2'b00,
        PH_RX = 2'b01,
        PH_IDLE = 2'b10
    } ppf_phase_e;

endpackage : ppf_pkg

// ==== hw/ppf_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock domain; depth is a power of two.
`timescale 1ns/100ps
module ppf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // Honest full and empty from the occupancy count
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer and count update
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage has no reset; reads are gated by valid
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
endmodule : ppf_fifo

// ==== test/ppf_line_partner.sv ====
// Far-side line partner: sends AMI receive bursts and decodes transmit bursts.
// Assumes its burst count starts with the framer's at reset release.
`timescale 1ns/100ps
module ppf_line_partner #(
    parameter logic [3:0] RX_T = 4'h6,
    parameter logic RX_S = 1'h1
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire ppf_pkg::ppf_sym_s i_line_tx,
    input wire logic i_line_tx_en,
    output logic o_line_rx_pos,
    output logic o_line_rx_neg,
    output logic [13:0] o_cyc,
    output logic [7:0] o_frames,
    output logic o_tx_done,
    output logic [7:0] o_tx_byte,
    output logic [3:0] o_tx_t,
    output logic o_tx_s,
    output logic [7:0] o_ami_err,
    output logic [15:0] o_en_last
);
    logic pol, tpol, tseen, b, m, sync;
    logic [7:0] rxb, tb;
    logic [15:0] en_cnt;
    int k;
    int j;
    ////////////////////////////////////////////////////////////////////////////////
    // One process: the line is idle zero outside frames, so no stale level lingers
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_cyc <= '0;
            o_frames <= '0;
            o_line_rx_pos <= 1'h0;
            o_line_rx_neg <= 1'h0;
            o_ami_err <= '0;
            en_cnt <= '0;
            tseen = 1'h0;
            pol = 1'h0;
        end else begin
            // 12500-cycle burst, receive half at 6250
            o_cyc <= (o_cyc == 14'd12499) ? 14'd0 : o_cyc + 14'd1;
            o_frames <= o_frames + 8'((o_cyc == 14'd12499));
            en_cnt <= (o_cyc == 14'd12499) ? 16'h0 : en_cnt + 16'(i_line_tx_en);
            if (o_cyc == 14'd12499) begin
                o_en_last <= en_cnt + 16'(i_line_tx_en);
            end
            // 38-bit frame, rotating M slot, sync as violation
            k = (int'(o_cyc) - 6250) / 130;
            rxb = 8'h30 + o_frames;
            sync = (o_frames[1:0] == 2'h0);
            if (o_cyc >= 14'd6250 && k <= 38 && (int'(o_cyc) - 6250) % 130 == 0) begin
                m = o_frames[0] ? RX_T[3 - o_frames[2:1]] : (o_frames[1] ? RX_S : 1'h1);
                b = (k == 0) || (k >= 1 && k <= 8 && rxb[8 - k]) || (k == 36 && m);
                // ones alternate unless this mark is the sync violation
                if (b && !(k == 36 && sync)) begin
                    pol = ~pol;
                end
                o_line_rx_pos <= b && pol;
                o_line_rx_neg <= b && !pol;
            end
            // Transmit decoding at mid-bit
            o_tx_done <= 1'h0;
            j = int'(o_cyc) / 130;
            if (o_cyc < 14'd4940 && o_cyc % 130 == 65) begin
                b = i_line_tx.pos | i_line_tx.neg;
                if ((i_line_tx.pos && i_line_tx.neg) || (j == 36 && sync && !b)) begin
                    o_ami_err <= o_ami_err + 8'h1;
                end
                if (b && tseen && ((i_line_tx.pos == tpol) != (j == 36 && sync))) begin
                    o_ami_err <= o_ami_err + 8'h1;
                end
                if (b) begin
                    tpol = i_line_tx.pos;
                    tseen = 1'h1;
                end
                if (j >= 1 && j <= 8) begin
                    tb <= {tb[6:0], b};
                end
                if (j == 36 && o_frames[0]) begin
                    o_tx_t <= {o_tx_t[2:0], b};
                end
                if (j == 36 && o_frames[1:0] == 2'h2) begin
                    o_tx_s <= b;
                end
                o_tx_done <= (j == 37);
                o_tx_byte <= tb;
            end
        end
    end
endmodule : ppf_line_partner

// ==== test/ppf_framer_tb.sv ====
// Testbench for the burst framer: host byte rows, superframe exchange, flags.
// Assumes the line partner model faces the framer's line pins.
`timescale 1ns/100ps
module ppf_framer_tb;
    logic i_clk_sys = 1'h0;
    logic i_srst = 1'h1;
    logic i_tx_valid = 1'h0;
    logic [7:0] i_tx_data = 8'h00;
    logic i_sf_tx_wr = 1'h0;
    logic [3:0] i_sf_tx_t_bits = 4'h0;
    logic i_sf_tx_svc = 1'h0;
    logic i_sf_rx_rd = 1'h0;
    logic o_tx_ready, o_rx_valid, o_line_tx_en, rx_pos, rx_neg, tx_done, tx_s;
    logic [7:0] o_rx_data, frames, tx_byte, ami_err;
    logic [13:0] cyc;
    logic [3:0] tx_t;
    logic [15:0] en_last;
    ppf_pkg::ppf_sf_rx_s o_sf_rx;
    ppf_pkg::ppf_sym_s o_line_tx;
    ppf_pkg::ppf_phase_e o_phase;
    int n_errors = 0;
    int tests_run = 0;
    int rx_n = 0;
    int cycles = 0;
    int w;
    // Byte pushed by the host beside the byte expected on the line
    logic [15:0] rows [4] = '{16'ha5a5, 16'h3c3c, 16'h8181, 16'h7e7e};

    ppf_framer u_ppf_framer (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .i_tx_data(i_tx_data),
        .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_sf_tx_wr(i_sf_tx_wr),
        .i_sf_tx_t_bits(i_sf_tx_t_bits), .i_sf_tx_svc(i_sf_tx_svc),
        .i_sf_rx_rd(i_sf_rx_rd), .o_sf_rx(o_sf_rx), .o_line_tx(o_line_tx),
        .o_line_tx_en(o_line_tx_en), .i_line_rx_pos(rx_pos), .i_line_rx_neg(rx_neg),
        .o_phase(o_phase));
    ppf_line_partner u_ppf_line_partner (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_line_tx(o_line_tx), .i_line_tx_en(o_line_tx_en), .o_line_rx_pos(rx_pos),
        .o_line_rx_neg(rx_neg), .o_cyc(cyc), .o_frames(frames), .o_tx_done(tx_done),
        .o_tx_byte(tx_byte), .o_tx_t(tx_t), .o_tx_s(tx_s), .o_ami_err(ami_err),
        .o_en_last(en_last));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge i_clk_sys);
        #1;
    endtask : tick
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // 50 MHz clock
    always #10 i_clk_sys = ~i_clk_sys;
    // Hang guard, a little above the eight bursts the run needs
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 103000) begin
            n_errors++;
            end_sim();
        end
    end
    // Monitor settled outputs: received bytes and phase against partner time
    always begin
        @(posedge i_clk_sys);
        #2;
        if (!i_srst && o_rx_valid === 1'h1) begin
            chk(16'(o_rx_data), 16'(8'h30 + 8'(rx_n)));
            rx_n++;
        end
        if (!i_srst && cyc == 14'd100) chk(16'(o_phase), 16'(ppf_pkg::PH_TX));
        if (!i_srst && cyc == 14'd6300) chk(16'(o_phase), 16'(ppf_pkg::PH_RX));
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_clk_sys);
        #1;
        i_srst = 1'h0;
        tick();
        chk(16'(o_sf_rx), 16'h0);
        // Load transmit group and service bit on the first accepted edge
        // all four T-bits at once
        i_sf_tx_wr = 1'h1;
        i_sf_tx_t_bits = 4'ha;
        i_sf_tx_svc = 1'h1;
        tick();
        i_sf_tx_wr = 1'h0;
        // Fill the FIFO back to back until it refuses
        for (int i = 0; i < 4; i++) begin
            chk(16'(o_tx_ready), 16'h1);
            i_tx_valid = 1'h1;
            i_tx_data = rows[i][15:8];
            tick();
        end
        i_tx_valid = 1'h0;
        chk(16'(o_tx_ready), 16'h0);
        // Drain: burst 0 carries idle ones, then one byte per burst in push order
        foreach (rows[i]) begin
            w = 0;
            tick();
            while (!(tx_done === 1'h1 && tx_byte !== 8'hff) && w < 70000) begin
                tick();
                w++;
            end
            chk(16'(tx_byte), 16'(rows[i][7:0]));
        end
        w = 0;
        while (o_sf_rx.rx_ready !== 1'h1 && w < 120000) begin
            tick();
            w++;
        end
        chk(16'(o_sf_rx.t_bits), 16'h6);
        chk(16'(o_sf_rx.svc), 16'h1);
        chk(16'(o_sf_rx.tx_request), 16'h1);
        chk(16'(tx_t), 16'ha);
        chk(16'(tx_s), 16'h1);
        chk(16'(ami_err), 16'h0);
        chk(en_last, 16'd4950);
        // One read clears both flags
        i_sf_rx_rd = 1'h1;
        tick();
        i_sf_rx_rd = 1'h0;
        tick();
        chk(16'({o_sf_rx.rx_ready, o_sf_rx.tx_request}), 16'h0);
        end_sim();
    end
endmodule : ppf_framer_tb
